// >>> hdl/tsfc_map.svh
// register offsets, field positions, reset values and codes of the task/fault unit
// assumes 32-bit AHB-Lite words, offsets compared on haddr[7:0]
`ifndef TSFC_MAP_SVH
`define TSFC_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TSFC_A_CMD 8'h00
`define TSFC_A_SEL 8'h04
`define TSFC_A_DESC 8'h08
`define TSFC_A_BASE 8'h0c
`define TSFC_A_TRSEL 8'h10
`define TSFC_A_TRBASE 8'h14
`define TSFC_A_TRLIM 8'h18
`define TSFC_A_MSW 8'h1c
`define TSFC_A_FLAGS 8'h20
`define TSFC_A_STATUS 8'h24
`define TSFC_A_RESULT 8'h28
`define TSFC_A_BOOT 8'h2c
`define TSFC_A_LINK 8'h30
// ----------------------------------------
// field positions
// ----------------------------------------
`define TSFC_MSW_PE 0
`define TSFC_MSW_MP 1
`define TSFC_MSW_TS 3
`define TSFC_FLG_ZF 6
`define TSFC_FLG_NT 14
// ----------------------------------------
// descriptor types, limits and vectors
// ----------------------------------------
`define TSFC_TYPE_TSS_FREE 4'h1
`define TSFC_TYPE_TSS_BUSY 4'h3
`define TSFC_TSS_MIN_LIM 16'h002b
`define TSFC_VEC_NOCOP 8'h07
`define TSFC_VEC_DOUBLE 8'h08
`define TSFC_VEC_BADTSS 8'h0a
`define TSFC_VEC_NOTPRES 8'h0b
`define TSFC_VEC_GP 8'h0d
// ----------------------------------------
// reset state of real mode
// ----------------------------------------
`define TSFC_BOOT_CS 16'hf000
`define TSFC_BOOT_IP 16'hfff0
`define TSFC_UPPER_HIGH 4'hf
`define TSFC_UPPER_LOW 4'h0
`endif

// >>> hdl/tsfc_pkg.sv
// types shared by the task/fault unit and its selector checker
// assumes the offsets and codes of tsfc_map.svh
package tsfc_pkg;
	typedef enum logic [4:0] {
		OP_NONE, OP_JMP_TASK, OP_CALL_TASK, OP_INT_TASK, OP_INTERRUPT_RETURN_INSTR, OP_INT_PLAIN,
		OP_ESCAPE, OP_WAIT, OP_ADJUST, OP_VER_READ, OP_VER_WRITE, OP_LOAD_LIMIT,
		OP_LOAD_RIGHTS, OP_RAISE, OP_INSTR_END, OP_EXC_DONE, OP_NMI, OP_LOAD_CS
	} tsfc_op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_LINK, ST_LOAD} tsfc_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] dpl;
		logic present;
		logic [3:0] dtype;
		logic [15:0] limit;
	} tsfc_desc_t;
	typedef struct packed {
		logic zf;
		logic fault;
		logic [7:0] vec;
		logic [15:0] value;
	} tsfc_check_t;
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} tsfc_exc_t;
endpackage

// >>> hdl/tsfc_sel_check.sv
// selector checker: pointer tests and task-target descriptor checks
// assumes the descriptor supplied is the one the selector references
`timescale 1ns/100ps
`include "tsfc_map.svh"
module tsfc_sel_check (
	input tsfc_pkg::tsfc_op_t op,
	input wire logic [15:0] selector,
	input wire logic [1:0] adjustRpl,
	input wire logic [1:0] curPriv,
	input tsfc_pkg::tsfc_desc_t desc,
	output tsfc_pkg::tsfc_check_t res
);
	import tsfc_pkg::*;
	function automatic logic [1:0] privMax(input logic [1:0] a, input logic [1:0] b);
		privMax = (a > b) ? a : b;
	endfunction
	logic privOk;
	logic isFree;
	logic isBusy;
	assign privOk = desc.dpl >= privMax(curPriv, selector[1:0]);
	assign isFree = desc.dtype == `TSFC_TYPE_TSS_FREE;
	assign isBusy = desc.dtype == `TSFC_TYPE_TSS_BUSY;
	always_comb begin
		res = '0;
		case (op)
			OP_ADJUST: begin
				res.value = {selector[15:2], privMax(selector[1:0], adjustRpl)};
				res.zf = adjustRpl > selector[1:0];
			end
			OP_VER_READ: res.zf = desc.present && desc.rd && privOk;
			OP_VER_WRITE: res.zf = desc.present && desc.wr && privOk;
			OP_LOAD_LIMIT: begin
				res.zf = desc.present && privOk && (desc.rd || desc.wr || isFree || isBusy);
				res.value = desc.limit;
			end
			OP_LOAD_RIGHTS: begin
				res.zf = desc.present && privOk;
				res.value = {desc.present, desc.dpl, 1'b1, desc.dtype, 8'h00};
			end
			OP_JMP_TASK, OP_CALL_TASK, OP_INT_TASK, OP_INTERRUPT_RETURN_INSTR: begin
				// the linked task of a return is legitimately busy
				if (!(isFree || isBusy)) begin
					res.fault = 1'b1;
					res.vec = `TSFC_VEC_GP;
				end else if (isBusy && op != OP_INTERRUPT_RETURN_INSTR) begin
					res.fault = 1'b1;
					res.vec = `TSFC_VEC_GP;
				end else if (desc.limit <= `TSFC_TSS_MIN_LIM) begin
					res.fault = 1'b1;
					res.vec = `TSFC_VEC_BADTSS;
				end else if (!desc.present) begin
					res.fault = 1'b1;
					res.vec = `TSFC_VEC_NOTPRES;
				end
			end
			default: res = '0;
		endcase
	end
endmodule

// >>> hdl/tsfc_unit.sv
// task switch, coprocessor fault, pointer test, double fault and boot control unit
// assumes an AHB-Lite master on core_clk; sequencer issues commands via CMD
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "tsfc_map.svh"
module tsfc_unit (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic segRefCode,
	output logic [3:0] addrUpper,
	output tsfc_pkg::tsfc_exc_t excOut,
	output logic shutdown,
	output logic haltCycle,
	output logic addressBitOne,
	output logic taskSave,
	output logic taskLoad,
	output logic markOldBusy,
	output logic markNewBusy,
	output logic popReturn
);
	import tsfc_pkg::*;
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] wrAddr_q;
	logic wrEn_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic [31:0] selReg_q;
	tsfc_desc_t desc_q;
	logic [23:0] baseReg_q;
	logic [15:0] trSel_q;
	logic [23:0] trBase_q;
	logic [15:0] trLim_q;
	logic [15:0] linkSel_q;
	logic mswPe_q;
	logic mswMp_q;
	logic mswTs_q;
	logic nt_q;
	logic zf_q;
	logic [15:0] result_q;
	tsfc_op_t cmdOp_q;
	logic cmdGo_q;
	tsfc_state_t state_q;
	tsfc_op_t kind_q;
	logic [15:0] newSel_q;
	logic [23:0] newBase_q;
	logic [15:0] newLim_q;
	logic excPend_q;
	logic dfActive_q;
	logic shutdown_q;
	tsfc_exc_t excOut_q;
	logic [7:0] lastVec_q;
	logic haltCycle_q;
	logic addressBitOne_q;
	logic csHigh_q;
	logic [15:0] codeSeg_q;
	logic [3:0] addrUpper_q;
	logic taskSave_q;
	logic taskLoad_q;
	logic markOldBusy_q;
	logic markNewBusy_q;
	logic popReturn_q;
	logic accept;
	logic raiseReq;
	logic [7:0] raiseVec;
	logic startSwitch;
	logic isPtrTest;
	logic [15:0] chkSel;
	tsfc_check_t chk;

	function automatic logic isTaskOp(input tsfc_op_t op);
		isTaskOp = op == OP_JMP_TASK || op == OP_CALL_TASK || op == OP_INT_TASK;
	endfunction

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign addrUpper = addrUpper_q;
	assign excOut = excOut_q;
	assign shutdown = shutdown_q;
	assign haltCycle = haltCycle_q;
	assign addressBitOne = addressBitOne_q;
	assign taskSave = taskSave_q;
	assign taskLoad = taskLoad_q;
	assign markOldBusy = markOldBusy_q;
	assign markNewBusy = markNewBusy_q;
	assign popReturn = popReturn_q;

	// ----------------------------------------
	// bus slave: zero wait, always OKAY
	// ----------------------------------------
	function automatic logic [31:0] regRead(input logic [7:0] a);
		case (a)
			`TSFC_A_CMD: regRead = {27'h0, cmdOp_q};
			`TSFC_A_SEL: regRead = selReg_q;
			`TSFC_A_DESC: regRead = {7'h0, desc_q};
			`TSFC_A_BASE: regRead = {8'h0, baseReg_q};
			`TSFC_A_TRSEL: regRead = {16'h0, trSel_q};
			`TSFC_A_TRBASE: regRead = {8'h0, trBase_q};
			`TSFC_A_TRLIM: regRead = {16'h0, trLim_q};
			`TSFC_A_MSW: regRead = {28'h0, mswTs_q, 1'b0, mswMp_q, mswPe_q};
			`TSFC_A_FLAGS: regRead = {17'h0, nt_q, 7'h0, zf_q, 6'h0};
			`TSFC_A_STATUS: regRead = {16'h0, lastVec_q, 3'h0, csHigh_q, excPend_q,
				dfActive_q, shutdown_q, state_q != ST_IDLE};
			`TSFC_A_RESULT: regRead = {16'h0, result_q};
			`TSFC_A_BOOT: regRead = {codeSeg_q, `TSFC_BOOT_IP};
			`TSFC_A_LINK: regRead = {16'h0, linkSel_q};
			default: regRead = 32'h0000_0000;
		endcase
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrEn_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
		end else begin
			wrEn_q <= hsel && hready && htrans[1] && hwrite;
			wrAddr_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite)
				hrdata_q <= regRead(haddr[7:0]);
			hreadyout_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			selReg_q <= 32'h0000_0000;
			desc_q <= '0;
			baseReg_q <= 24'h000000;
			cmdOp_q <= OP_NONE;
			cmdGo_q <= 1'b0;
		end else begin
			cmdGo_q <= wrEn_q && wrAddr_q == `TSFC_A_CMD;
			if (wrEn_q) begin
				case (wrAddr_q)
					`TSFC_A_CMD: cmdOp_q <= tsfc_op_t'(hwdata[4:0]);
					`TSFC_A_SEL: selReg_q <= hwdata;
					`TSFC_A_DESC: desc_q <= tsfc_desc_t'(hwdata[24:0]);
					`TSFC_A_BASE: baseReg_q <= hwdata[23:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// commands during a switch or in shutdown are dropped, except an NMI in shutdown
	assign accept = cmdGo_q && !shutdown_q && state_q == ST_IDLE;
	assign chkSel = cmdOp_q == OP_INTERRUPT_RETURN_INSTR ? linkSel_q : selReg_q[15:0];
	assign isPtrTest = cmdOp_q == OP_ADJUST || cmdOp_q == OP_VER_READ ||
		cmdOp_q == OP_VER_WRITE || cmdOp_q == OP_LOAD_LIMIT || cmdOp_q == OP_LOAD_RIGHTS;

	tsfc_sel_check u_check (
		.op(cmdOp_q),
		.selector(chkSel),
		.adjustRpl(selReg_q[17:16]),
		.curPriv(selReg_q[19:18]),
		.desc(desc_q),
		.res(chk)
	);

	always_comb begin
		raiseReq = 1'b0;
		raiseVec = 8'h00;
		startSwitch = 1'b0;
		if (accept) begin
			case (cmdOp_q)
				OP_JMP_TASK, OP_CALL_TASK, OP_INT_TASK, OP_INTERRUPT_RETURN_INSTR: begin
					if (cmdOp_q != OP_INTERRUPT_RETURN_INSTR || nt_q) begin
						raiseReq = chk.fault;
						raiseVec = chk.vec;
						startSwitch = !chk.fault;
					end
				end
				OP_ESCAPE, OP_WAIT: begin
					raiseReq = mswTs_q && mswMp_q;
					raiseVec = `TSFC_VEC_NOCOP;
				end
				OP_RAISE: begin
					raiseReq = 1'b1;
					raiseVec = selReg_q[7:0];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// task switch sequence
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			kind_q <= OP_NONE;
			newSel_q <= 16'h0000;
			newBase_q <= 24'h000000;
			newLim_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_IDLE: if (startSwitch) begin
					kind_q <= cmdOp_q;
					newSel_q <= chkSel;
					newBase_q <= baseReg_q;
					newLim_q <= desc_q.limit;
					state_q <= ST_SAVE;
				end
				ST_SAVE: state_q <= ST_LINK;
				ST_LINK: state_q <= ST_LOAD;
				ST_LOAD: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			taskSave_q <= 1'b0;
			markOldBusy_q <= 1'b0;
			markNewBusy_q <= 1'b0;
			taskLoad_q <= 1'b0;
			popReturn_q <= 1'b0;
		end else begin
			taskSave_q <= state_q == ST_SAVE;
			markOldBusy_q <= state_q == ST_LINK && kind_q != OP_JMP_TASK && kind_q != OP_INTERRUPT_RETURN_INSTR;
			markNewBusy_q <= state_q == ST_LINK && kind_q != OP_INTERRUPT_RETURN_INSTR;
			taskLoad_q <= state_q == ST_LOAD;
			popReturn_q <= accept && cmdOp_q == OP_INTERRUPT_RETURN_INSTR && !nt_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trSel_q <= 16'h0000;
			trBase_q <= 24'h000000;
			trLim_q <= 16'h0000;
			linkSel_q <= 16'h0000;
		end else if (state_q == ST_LOAD) begin
			trSel_q <= newSel_q;
			trBase_q <= newBase_q;
			trLim_q <= newLim_q;
			if (kind_q != OP_INTERRUPT_RETURN_INSTR)
				linkSel_q <= trSel_q;
		end
	end

	// ----------------------------------------
	// status word and flags; hardware wins over a same-cycle write
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mswPe_q <= 1'b0;
			mswMp_q <= 1'b0;
			mswTs_q <= 1'b0;
		end else begin
			if (wrEn_q && wrAddr_q == `TSFC_A_MSW) begin
				// protection cannot be switched off again by software
				mswPe_q <= mswPe_q | hwdata[`TSFC_MSW_PE];
				mswMp_q <= hwdata[`TSFC_MSW_MP];
				mswTs_q <= hwdata[`TSFC_MSW_TS];
			end
			if (state_q == ST_LOAD)
				mswTs_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			nt_q <= 1'b0;
			zf_q <= 1'b0;
			result_q <= 16'h0000;
		end else begin
			if (wrEn_q && wrAddr_q == `TSFC_A_FLAGS) begin
				nt_q <= hwdata[`TSFC_FLG_NT];
				zf_q <= hwdata[`TSFC_FLG_ZF];
			end
			if (accept && cmdOp_q == OP_INT_PLAIN)
				nt_q <= 1'b0;
			if (state_q == ST_LOAD && (kind_q == OP_CALL_TASK || kind_q == OP_INT_TASK))
				nt_q <= 1'b1;
			if (accept && isPtrTest) begin
				zf_q <= chk.zf;
				if (chk.zf || cmdOp_q == OP_ADJUST)
					result_q <= chk.value;
			end
		end
	end

	// ----------------------------------------
	// exceptions, double fault, shutdown
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			excPend_q <= 1'b0;
			dfActive_q <= 1'b0;
			shutdown_q <= 1'b0;
			excOut_q <= '0;
			lastVec_q <= 8'h00;
			haltCycle_q <= 1'b0;
			addressBitOne_q <= 1'b1;
		end else begin
			excOut_q.valid <= 1'b0;
			haltCycle_q <= 1'b0;
			addressBitOne_q <= 1'b1;
			if (accept && cmdOp_q == OP_INSTR_END)
				excPend_q <= 1'b0;
			if (accept && cmdOp_q == OP_EXC_DONE)
				dfActive_q <= 1'b0;
			if (cmdGo_q && cmdOp_q == OP_NMI && shutdown_q) begin
				shutdown_q <= 1'b0;
				dfActive_q <= 1'b0;
				excPend_q <= 1'b0;
			end
			if (raiseReq) begin
				if (dfActive_q) begin
					shutdown_q <= 1'b1;
					haltCycle_q <= 1'b1;
					addressBitOne_q <= 1'b0;
				end else if (excPend_q) begin
					excOut_q <= '{valid: 1'b1, vector: `TSFC_VEC_DOUBLE};
					lastVec_q <= `TSFC_VEC_DOUBLE;
					dfActive_q <= 1'b1;
				end else begin
					excOut_q <= '{valid: 1'b1, vector: raiseVec};
					lastVec_q <= raiseVec;
					excPend_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// real-mode boot address forcing
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			csHigh_q <= 1'b1;
			codeSeg_q <= `TSFC_BOOT_CS;
			addrUpper_q <= `TSFC_UPPER_LOW;
		end else begin
			if (accept && cmdOp_q == OP_LOAD_CS) begin
				codeSeg_q <= selReg_q[15:0];
				if (!mswPe_q)
					csHigh_q <= 1'b0;
			end
			addrUpper_q <= (!mswPe_q && csHigh_q && segRefCode) ?
				`TSFC_UPPER_HIGH : `TSFC_UPPER_LOW;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_switch_sequence: assert property (accept && startSwitch |-> ##2 taskSave_q ##2 taskLoad_q)
		else $error("task switch sequence broken");
	a_short_tss: assert property (accept && isTaskOp(cmdOp_q) &&
		desc_q.limit <= `TSFC_TSS_MIN_LIM |=> excOut_q.valid || shutdown_q)
		else $error("short task segment accepted");
	a_hidden_regs: assert property (taskLoad_q |-> trLim_q == newLim_q && trBase_q == newBase_q)
		else $error("hidden base or limit not loaded");
	a_interrupt_return_instr_plain: assert property (accept && cmdOp_q == OP_INTERRUPT_RETURN_INSTR && !nt_q |=>
		popReturn_q && state_q == ST_IDLE)
		else $error("plain return misbehaved");
	a_busy_marks: assert property (markNewBusy_q |->
		(markOldBusy_q == (kind_q != OP_JMP_TASK)) ##1 taskLoad_q)
		else $error("busy marking out of step");
	a_nested_set: assert property (taskLoad_q && (kind_q == OP_CALL_TASK ||
		kind_q == OP_INT_TASK) |-> nt_q)
		else $error("nested flag not set");
	a_busy_fault: assert property (accept && isTaskOp(cmdOp_q) &&
		desc_q.dtype == `TSFC_TYPE_TSS_BUSY |=> !taskSave_q ##1 !taskSave_q)
		else $error("busy task segment used");
	a_escape_fault: assert property (accept && cmdOp_q == OP_ESCAPE && mswTs_q && mswMp_q &&
		!dfActive_q |=> excOut_q.valid)
		else $error("coprocessor fault missing");
	a_switch_ts: assert property (taskLoad_q |-> mswTs_q)
		else $error("task-switched flag not set");
	a_ptr_quiet: assert property (accept && isPtrTest |=> !excOut_q.valid && !shutdown_q)
		else $error("pointer test raised exception");
	a_double_vec: assert property (raiseReq && excPend_q && !dfActive_q |=>
		excOut_q.valid && excOut_q.vector == `TSFC_VEC_DOUBLE)
		else $error("double fault vector wrong");
	a_shutdown_in: assert property (raiseReq && dfActive_q |=>
		shutdown_q && haltCycle_q && !addressBitOne_q)
		else $error("shutdown entry wrong");
	a_nmi_exit: assert property (cmdGo_q && cmdOp_q == OP_NMI && shutdown_q |=>
		!shutdown_q && $stable(mswPe_q))
		else $error("nmi did not leave shutdown");
	a_code_upper: assert property (!mswPe_q && segRefCode |=>
		addrUpper_q == ($past(csHigh_q) ? `TSFC_UPPER_HIGH : `TSFC_UPPER_LOW))
		else $error("upper address wrong");

	c_task_switch: cover property (taskLoad_q && kind_q == OP_CALL_TASK);
	c_double_fault: cover property (excOut_q.valid && excOut_q.vector == `TSFC_VEC_DOUBLE);
	c_shutdown_nmi: cover property (shutdown_q ##[1:50] !shutdown_q);
	c_verify_ok: cover property (accept && cmdOp_q == OP_VER_READ && chk.zf);
endmodule

// >>> tb/tb.sv
// self-checking bench of the task/fault unit
// assumes zero-wait AHB-Lite slave and commands settled 7 cycles after the write
`timescale 1ns/100ps
`include "tsfc_map.svh"
module tb;
	import tsfc_pkg::*;
	logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, segRefCode = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, r1, mx;
	logic [2:0] hsize = 3'h2;
	logic [3:0] addrUpper;
	logic [15:0] sel;
	logic [31:0] ptrSel, ptrDesc, oldRes;
	logic [16:0] pe;
	logic hready, hreadyout, hresp, shutdown, haltCycle, addressBitOne;
	logic taskSave, taskLoad, markOldBusy, markNewBusy, popReturn;
	logic [7:0] lastVec = 0;
	tsfc_exc_t excOut;
	int nErrors = 0, numChecks = 0, seed = 87, k, shutSeen, haltSeen;
	int nExc = 0, nLoad = 0, nPop = 0, nOld = 0, nNew = 0, nSave = 0;
	assign hready = hreadyout;
	always #12.5 core_clk = ~core_clk;
	tsfc_unit DUT (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .segRefCode, .addrUpper, .excOut, .shutdown,
		.haltCycle, .addressBitOne, .taskSave, .taskLoad, .markOldBusy, .markNewBusy,
		.popReturn);
	tsfc_bus_decoder PART (.core_clk, .haltCycle, .addressBitOne,
		.shutdownSeen(shutSeen), .haltSeen);
	// ------
	// pulse counters
	// ------
	always @(posedge core_clk) begin
		if (excOut.valid === 1'b1) begin
			nExc++;
			lastVec = excOut.vector;
		end
		nLoad += (taskLoad === 1'b1);
		nSave += (taskSave === 1'b1);
		nPop += (popReturn === 1'b1);
		nOld += (markOldBusy === 1'b1);
		nNew += (markNewBusy === 1'b1);
	end
	// ------
	// tasks
	// ------
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		rd = hrdata;
		chk("hresp", hresp, 32'h0);
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	// expected zero flag and result of a pointer test; verify tests that set the flag leave a zero result
	function automatic logic [16:0] ptrExp(input logic [4:0] op, input logic [31:0] s,
		input logic [31:0] d);
		logic ok;
		logic z;
		logic [15:0] v;
		ok = d[22:21] >= ((s[19:18] > s[1:0]) ? s[19:18] : s[1:0]);
		v = 16'h0000;
		case (op)
			5'd9: z = d[20] && d[23] && ok;
			5'd10: z = d[20] && d[24] && ok;
			5'd11: begin
				z = d[20] && ok && (d[23] || d[24] || d[19:16] == `TSFC_TYPE_TSS_FREE ||
					d[19:16] == `TSFC_TYPE_TSS_BUSY);
				v = d[15:0];
			end
			default: begin
				z = d[20] && ok;
				v = {d[20], d[22:21], 1'b1, d[19:16], 8'h00};
			end
		endcase
		ptrExp = {z, v};
	endfunction
	// fin closes the instruction so later raises start afresh
	task ex(input logic [4:0] op, input bit fin);
		bus(1, `TSFC_A_CMD, {27'h0, op});
		repeat (7) @(posedge core_clk);
		if (fin) begin
			bus(1, `TSFC_A_CMD, 32'he);
			repeat (3) @(posedge core_clk);
		end
	endtask
	task test_done;
		if (nErrors == 0 && numChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		nErrors++;
		test_done;
	end
	// ------
	// scenarios
	// ------
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		rdchk("boot", `TSFC_A_BOOT, {`TSFC_BOOT_CS, `TSFC_BOOT_IP});
		for (int i = 0; i < 4; i++) begin
			segRefCode <= i[0];
			repeat (2) @(posedge core_clk);
			chk("upper", addrUpper, i[0] ? `TSFC_UPPER_HIGH : `TSFC_UPPER_LOW);
		end
		segRefCode <= 1;
		ex(5'd17, 1);
		chk("upper", addrUpper, `TSFC_UPPER_LOW);
		bus(1, `TSFC_A_SEL, 32'h30);
		bus(1, `TSFC_A_DESC, 32'h0011002c);
		bus(1, `TSFC_A_BASE, 32'h012340);
		ex(5'd2, 1);
		chk("pulses", {nSave[7:0], nOld[7:0], nNew[7:0], nLoad[7:0]}, 32'h01010101);
		rdchk("trsel", `TSFC_A_TRSEL, 32'h30);
		rdchk("trbase", `TSFC_A_TRBASE, 32'h012340);
		rdchk("trlim", `TSFC_A_TRLIM, 32'h2c);
		rdchk("link", `TSFC_A_LINK, 32'h0);
		rdchk("msw", `TSFC_A_MSW, 32'h8);
		bus(0, `TSFC_A_FLAGS, 32'h0);
		chk("nt", rd[14], 1);
		bus(1, `TSFC_A_SEL, 32'h38);
		ex(5'd1, 1);
		chk("pulses", {nSave[7:0], nOld[7:0], nNew[7:0], nLoad[7:0]}, 32'h02010202);
		rdchk("link", `TSFC_A_LINK, 32'h30);
		ex(5'd4, 1);
		chk("interrupt_return_instr", {nPop[7:0], nLoad[7:0]}, 32'h3);
		ex(5'd5, 1);
		bus(0, `TSFC_A_FLAGS, 32'h0);
		chk("nt", rd[14], 0);
		ex(5'd4, 1);
		chk("interrupt_return_instr", {nPop[7:0], nLoad[7:0]}, 32'h103);
		ex(5'd3, 1);
		bus(0, `TSFC_A_FLAGS, 32'h0);
		chk("nt", rd[14], 1);
		bus(1, `TSFC_A_DESC, 32'h0011002b);
		ex(5'd1, 1);
		chk("vec", lastVec, `TSFC_VEC_BADTSS);
		bus(1, `TSFC_A_DESC, 32'h0013002c);
		ex(5'd2, 1);
		chk("vec", lastVec, `TSFC_VEC_GP);
		chk("loads", nLoad, 4);
		for (int i = 0; i < 4; i++) begin
			k = nExc;
			bus(1, `TSFC_A_MSW, {28'h0, i[1], 1'b0, i[0], 1'b0});
			ex(i[0] ? 5'd6 : 5'd7, 1);
			chk("nocop", nExc - k, i == 3);
			if (i == 3) chk("vec", lastVec, `TSFC_VEC_NOCOP);
		end
		k = nExc;
		ex(5'd7, 1);
		chk("nocop", nExc - k, 1);
		for (int i = 0; i < 8; i++) begin
			sel = $random(seed);
			r1 = $random(seed);
			if (i == 0) sel[1:0] = r1;
			mx = (sel[1:0] > r1) ? sel[1:0] : r1;
			k = nExc;
			bus(1, `TSFC_A_SEL, {14'h0, r1, sel});
			ex(5'd8, 1);
			rdchk("adjust", `TSFC_A_RESULT, {16'h0, sel[15:2], mx});
			bus(0, `TSFC_A_FLAGS, 32'h0);
			chk("zf", rd[6], mx != sel[1:0]);
			chk("noexc", nExc, k);
		end
		for (int i = 0; i < 16; i++) begin
			ptrSel = $random(seed);
			ptrDesc = $random(seed);
			// first pass of each test uses a fully permitted descriptor
			if (i < 4) ptrDesc[24:20] = 5'h1f;
			bus(1, `TSFC_A_SEL, {12'h0, ptrSel[19:0]});
			bus(1, `TSFC_A_DESC, {7'h0, ptrDesc[24:0]});
			bus(0, `TSFC_A_RESULT, 32'h0);
			oldRes = rd;
			pe = ptrExp(5'd9 + i[1:0], {12'h0, ptrSel[19:0]}, ptrDesc);
			k = nExc;
			ex(5'd9 + i[1:0], 1);
			rdchk("ptrres", `TSFC_A_RESULT, pe[16] ? {16'h0, pe[15:0]} : oldRes);
			bus(0, `TSFC_A_FLAGS, 32'h0);
			chk("ptrzf", rd[6], pe[16]);
			chk("ptrexc", nExc, k);
		end
		bus(1, `TSFC_A_MSW, 32'h1);
		bus(1, `TSFC_A_SEL, 32'hd);
		ex(5'd13, 0);
		ex(5'd13, 0);
		chk("vec", lastVec, `TSFC_VEC_DOUBLE);
		k = nExc;
		ex(5'd13, 0);
		chk("shut", {shutdown, haltSeen[7:0], shutSeen[7:0]}, 32'h10101);
		ex(5'd13, 0);
		chk("quiet", nExc, k);
		ex(5'd16, 0);
		chk("shut", shutdown, 0);
		rdchk("msw", `TSFC_A_MSW, 32'h1);
		ex(5'd15, 1);
		rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		repeat (2) @(posedge core_clk);
		chk("upper", addrUpper, `TSFC_UPPER_HIGH);
		rdchk("msw", `TSFC_A_MSW, 32'h0);
		test_done;
	end
endmodule

// >>> tb/tsfc_bus_decoder.sv
// external status decoder model that watches halt-type bus operations
// assumes haltCycle is a one-cycle pulse and addressBitOne is valid with it
`timescale 1ns/100ps
module tsfc_bus_decoder (
	input wire logic core_clk,
	input wire logic haltCycle,
	input wire logic addressBitOne,
	output int shutdownSeen,
	output int haltSeen
);
	initial begin
		shutdownSeen = 0;
		haltSeen = 0;
	end
	// counts survive a reset of the unit, as board logic would
	always @(posedge core_clk) begin
		if (haltCycle === 1'b1) begin
			haltSeen++;
			if (addressBitOne === 1'b0) shutdownSeen++;
		end
	end
endmodule
